// ==== design/pimg_consts.svh ====
`ifndef PIMG_CONSTS_SVH
`define PIMG_CONSTS_SVH
// ------------------------------------------------------------
// register map (byte addresses, word aligned)
// ------------------------------------------------------------
`define ADDR_CTRL 6'h00
`define ADDR_PINS 6'h04
`define ADDR_STAT_LO 6'h08
`define ADDR_STAT_HI 6'h0C
`define ADDR_TIME 6'h10
`define ADDR_IRQ_STAT 6'h14
`define ADDR_IRQ_CLR 6'h18
`define ADDR_IRQ_EN 6'h1C
`define ADDR_CYCLE 6'h20
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CTRL_PACK_BIT 0
`define CTRL_HIST_BIT 4
`define CTRL_REFCLK_BIT 8
// ------------------------------------------------------------
// status byte codes
// ------------------------------------------------------------
`define LINK_INACTIVE 4'h0
`define LINK_SIO_IN 4'h1
`define LINK_SIO_OUT 4'h2
`define LINK_OPERATING 4'h3
`define LINK_STOPPED 4'h4
`define ERR_NONE 4'h0
`define ERR_WATCHDOG 4'h1
`define ERR_OVERFLOW 4'h2
`define ERR_DEVICE_ID 4'h3
`define ERR_VENDOR_ID 4'h4
`define ERR_REVISION 4'h5
`define ERR_FRAME_CAP 4'h6
`define ERR_CYCLE_TIME 4'h7
`define ERR_LENGTH_A 4'h8
`define ERR_LENGTH_B 4'h9
`define ERR_NO_DEVICE 4'hA
`define ERR_PREOP 4'hB
// ------------------------------------------------------------
// interrupt bits
// ------------------------------------------------------------
`define IRQ_CYCLE_BIT 0
`define IRQ_NEWMSG_BIT 1
`define IRQ_WRAP_BIT 2
`define IRQ_W 3
`define TS_W 32
`define NPORT 8
`endif

// ==== design/pimg_pkg.sv ====
package pimg_pkg;
   typedef struct packed {
      logic [7:0] pin4_s1;
      logic [7:0] pin4_s2;
      logic [7:0] pin4_s3;
      logic [7:0] pin2_s1;
      logic [7:0] pin2_s2;
      logic [7:0] pin2_s3;
      logic [7:0] pin4;
      logic [7:0] pin2;
      logic pack_sel;
      logic hist_ack;
      logic ref_clk_en;
      logic [2:0] irq_stat;
      logic [2:0] irq_en;
      logic [31:0] ts;
      logic [15:0] img_in;
      logic img_new;
      logic [63:0] img_stat;
      logic [31:0] img_ts;
      logic img_valid;
      logic new_prev;
      logic ack;
      logic [31:0] dat;
   } state_t;
endpackage

// ==== design/process_image.sv ====
// How it works
// [R1] port-based packing puts port n pin-4 in bit 2n and pin-2 in bit 2n+1, ports 0-3 in byte 0, ports 4-7 in byte 1.
// [R2] pin-based packing puts pin-4 of ports 0-7 in byte 0 bits 0-7 and pin-2 of ports 0-7 in byte 1.
// [R3] in overwrite mode the new-message flag is 1 while the newest message is unread, else 0.
// [R4] in acknowledge mode the new-message flag is 1 while any acknowledgeable message is pending.
// [R5] the image carries exactly one status byte per port, eight in all.
// [R6] each status low nibble is the link state code 0 to 4.
// [R7] each status high nibble is the validation error code 0x00 to 0x90.
// [R8] the high nibble reads 0xA0 for no device detected and 0xB0 for a pre-operational failure.
// [R9] the block can serve as distributed-clock reference and sends its timestamp with the image.
// [R10] the timestamp counter is 32 bits and wraps.
// [R11] port sampling is free running and never waits on a sync event.
// [R12] input_packing_select 0 picks port-based, 1 picks pin-based; port-based after reset.
// [R13] the history mode bit picks overwrite (0) or acknowledge (1).
// [R14] status bytes go in ascending port order and the whole image updates in one cycle.
`include "pimg_consts.svh"
module process_image (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] pin4_i,
   input wire logic [7:0] pin2_i,
   input wire logic [31:0] link_state_i,
   input wire logic [31:0] err_code_i,
   input wire logic newest_unread_i,
   input wire logic ack_pending_i,
   input wire logic cycle_i,
   output logic [15:0] image_inputs_o,
   output logic image_new_msg_o,
   output logic [63:0] image_status_o,
   output logic [31:0] image_time_o,
   output logic image_valid_o,
   output logic ref_clock_o,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o
);
   pimg_pkg::state_t q, d;
   logic [15:0] packed_in;
   logic [63:0] stat_bytes;
   logic new_flag;
   logic wr, rd;
   logic [2:0] ev;

   // ------------------------------------------------------------
   // image assembly
   // ------------------------------------------------------------
   always_comb begin
      packed_in = 16'h0000;
      stat_bytes = 64'h0000000000000000;
      for (int p = 0; p < `NPORT; p++) begin
         if (q.pack_sel) begin
            packed_in[p] = q.pin4[p]; // [R2]
            packed_in[p + 8] = q.pin2[p]; // [R2]
         end else begin
            packed_in[2 * p] = q.pin4[p]; // [R1]
            packed_in[2 * p + 1] = q.pin2[p]; // [R1]
         end
         // low nibble link state, high nibble error code, port 0 lowest byte
         stat_bytes[8 * p +: 8] = {err_code_i[4 * p +: 4], link_state_i[4 * p +: 4]}; // [R5] [R6] [R7] [R8] [R14]
      end
   end

   assign new_flag = q.hist_ack ? ack_pending_i : newest_unread_i; // [R3] [R4] [R13]
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !q.ack;
   assign ev[`IRQ_CYCLE_BIT] = cycle_i;
   assign ev[`IRQ_NEWMSG_BIT] = new_flag && !q.new_prev;
   assign ev[`IRQ_WRAP_BIT] = &q.ts;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      // three-stage sync, free running with no sync-event gating
      d.pin4_s1 = pin4_i; // [R11]
      d.pin4_s2 = q.pin4_s1;
      d.pin4_s3 = q.pin4_s2;
      d.pin2_s1 = pin2_i;
      d.pin2_s2 = q.pin2_s1;
      d.pin2_s3 = q.pin2_s2;
      for (int p = 0; p < `NPORT; p++) begin
         if (q.pin4_s2[p] == q.pin4_s3[p]) d.pin4[p] = q.pin4_s3[p];
         if (q.pin2_s2[p] == q.pin2_s3[p]) d.pin2[p] = q.pin2_s3[p];
      end
      d.ts = q.ts + 32'h00000001; // [R10]
      // edge detector rests at 0, the idle level of the flag, so leaving reset gives no false edge
      d.new_prev = new_flag;
      d.ack = 1'b0;
      d.dat = 32'h00000000;
      if (cycle_i) begin
         d.img_in = packed_in; // [R14]
         d.img_new = new_flag;
         d.img_stat = stat_bytes; // [R14]
         d.img_ts = q.ts; // [R9]
         d.img_valid = 1'b1;
      end
      // events are or-ed in after any clear, so an event in the clear cycle is never lost
      d.irq_stat = q.irq_stat | ev;
      // ack is registered: one wait state, and a request already acked is not taken twice
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         d.ack = 1'b1;
         if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
               `ADDR_CTRL: begin
                  d.pack_sel = wb_dat_i[`CTRL_PACK_BIT]; // [R12]
                  d.hist_ack = wb_dat_i[`CTRL_HIST_BIT]; // [R13]
               end
               `ADDR_IRQ_CLR: d.irq_stat = (q.irq_stat & ~wb_dat_i[`IRQ_W-1:0]) | ev;
               `ADDR_IRQ_EN: d.irq_en = wb_dat_i[`IRQ_W-1:0];
               default: ;
            endcase
         end
         if (wr && wb_sel_i[1] && wb_adr_i == `ADDR_CTRL)
            d.ref_clk_en = wb_dat_i[`CTRL_REFCLK_BIT]; // [R9]
         if (rd) begin
            case (wb_adr_i)
               `ADDR_CTRL: d.dat = {23'h000000, q.ref_clk_en, 3'h0, q.hist_ack, 3'h0, q.pack_sel};
               `ADDR_PINS: d.dat = {16'h0000, q.pin2, q.pin4};
               `ADDR_STAT_LO: d.dat = stat_bytes[31:0];
               `ADDR_STAT_HI: d.dat = stat_bytes[63:32];
               `ADDR_TIME: d.dat = q.ts;
               `ADDR_IRQ_STAT: d.dat = {29'h00000000, q.irq_stat};
               `ADDR_IRQ_EN: d.dat = {29'h00000000, q.irq_en};
               `ADDR_CYCLE: d.dat = {15'h0000, new_flag, packed_in};
               default: d.dat = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0; // port-based packing, overwrite mode [R12]
      end else begin
         q <= d;
      end
   end

   assign image_inputs_o = q.img_in;
   assign image_new_msg_o = q.img_new;
   assign image_status_o = q.img_stat;
   assign image_time_o = q.img_ts;
   assign image_valid_o = q.img_valid;
   assign ref_clock_o = q.ref_clk_en;
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign irq_o = |(q.irq_stat & q.irq_en);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_port_pack;
      @(posedge clk_i) disable iff (rst_i)
      (cycle_i && !q.pack_sel) |=> image_inputs_o == {
         $past(q.pin2[7]), $past(q.pin4[7]), $past(q.pin2[6]), $past(q.pin4[6]),
         $past(q.pin2[5]), $past(q.pin4[5]), $past(q.pin2[4]), $past(q.pin4[4]),
         $past(q.pin2[3]), $past(q.pin4[3]), $past(q.pin2[2]), $past(q.pin4[2]),
         $past(q.pin2[1]), $past(q.pin4[1]), $past(q.pin2[0]), $past(q.pin4[0])};
   endproperty
   a_port_pack: assert property (p_port_pack) else $error("port-based packing wrong"); // [R1]
   property p_pin_pack;
      @(posedge clk_i) disable iff (rst_i)
      (cycle_i && q.pack_sel) |=> image_inputs_o == {$past(q.pin2), $past(q.pin4)};
   endproperty
   a_pin_pack: assert property (p_pin_pack) else $error("pin-based packing wrong"); // [R2]
   property p_overwrite_flag;
      @(posedge clk_i) disable iff (rst_i)
      (cycle_i && !q.hist_ack) |=> image_new_msg_o == $past(newest_unread_i);
   endproperty
   a_overwrite_flag: assert property (p_overwrite_flag) else $error("overwrite flag wrong"); // [R3]
   property p_ack_flag;
      @(posedge clk_i) disable iff (rst_i)
      (cycle_i && q.hist_ack) |=> image_new_msg_o == $past(ack_pending_i);
   endproperty
   a_ack_flag: assert property (p_ack_flag) else $error("acknowledge flag wrong"); // [R4]
   property p_status_order;
      @(posedge clk_i) disable iff (rst_i)
      cycle_i |=> image_status_o[7:0] == {$past(err_code_i[3:0]), $past(link_state_i[3:0])}
         && image_status_o[63:56] == {$past(err_code_i[31:28]), $past(link_state_i[31:28])};
   endproperty
   a_status_order: assert property (p_status_order) else $error("status byte order wrong"); // [R5]
   property p_link_nibble;
      @(posedge clk_i) disable iff (rst_i)
      cycle_i |=> image_status_o[35:32] == $past(link_state_i[19:16]);
   endproperty
   a_link_nibble: assert property (p_link_nibble) else $error("link nibble wrong"); // [R6]
   property p_err_nibble;
      @(posedge clk_i) disable iff (rst_i)
      cycle_i |=> image_status_o[47:44] == $past(err_code_i[23:20]);
   endproperty
   a_err_nibble: assert property (p_err_nibble) else $error("error nibble wrong"); // [R7]
   property p_ts_wrap;
      @(posedge clk_i) disable iff (rst_i)
      (q.ts == 32'hFFFFFFFF) |=> q.ts == 32'h00000000;
   endproperty
   a_ts_wrap: assert property (p_ts_wrap) else $error("timestamp did not wrap"); // [R10]
   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      !cycle_i |=> $stable(image_inputs_o) && $stable(image_status_o) && $stable(image_time_o);
   endproperty
   a_hold: assert property (p_hold) else $error("image changed outside a cycle"); // [R14]
   sequence s_ctrl_write;
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `ADDR_CTRL && wb_sel_i[0];
   endsequence
   property p_pack_select;
      @(posedge clk_i) disable iff (rst_i)
      s_ctrl_write |=> q.pack_sel == $past(wb_dat_i[`CTRL_PACK_BIT]) && wb_ack_o;
   endproperty
   a_pack_select: assert property (p_pack_select) else $error("packing select not taken"); // [R12]
   property p_hist_select;
      @(posedge clk_i) disable iff (rst_i)
      s_ctrl_write |=> q.hist_ack == $past(wb_dat_i[`CTRL_HIST_BIT]);
   endproperty
   a_hist_select: assert property (p_hist_select) else $error("history mode not taken"); // [R13]
   sequence s_refclk_write;
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `ADDR_CTRL && wb_sel_i[1];
   endsequence
   property p_ref_clock;
      @(posedge clk_i) disable iff (rst_i)
      s_refclk_write |=> ref_clock_o == $past(wb_dat_i[`CTRL_REFCLK_BIT]);
   endproperty
   a_ref_clock: assert property (p_ref_clock) else $error("reference clock enable not taken"); // [R9]
   property p_time_capture;
      @(posedge clk_i) disable iff (rst_i)
      cycle_i |=> image_time_o == $past(q.ts) && image_valid_o;
   endproperty
   a_time_capture: assert property (p_time_capture) else $error("timestamp not captured"); // [R9]
   // one step per clock: the wrap at 32 bits follows from the width
   property p_ts_step;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> q.ts == $past(q.ts) + 32'h00000001;
   endproperty
   a_ts_step: assert property (p_ts_step) else $error("timestamp did not step"); // [R10]
   property p_no_device;
      @(posedge clk_i) disable iff (rst_i)
      (cycle_i && err_code_i[3:0] == `ERR_NO_DEVICE) |=> image_status_o[7:4] == `ERR_NO_DEVICE;
   endproperty
   a_no_device: assert property (p_no_device) else $error("no-device code lost"); // [R8]
   property p_preop_fail;
      @(posedge clk_i) disable iff (rst_i)
      (cycle_i && err_code_i[31:28] == `ERR_PREOP) |=> image_status_o[63:60] == `ERR_PREOP;
   endproperty
   a_preop_fail: assert property (p_preop_fail) else $error("pre-operational failure code lost"); // [R8]
   // a pin change passes only once the second and third stages agree
   property p_pin_filter;
      @(posedge clk_i) disable iff (rst_i)
      (q.pin4_s2 == q.pin4_s3 && q.pin2_s2 == q.pin2_s3)
         |=> q.pin4 == $past(q.pin4_s3) && q.pin2 == $past(q.pin2_s3);
   endproperty
   a_pin_filter: assert property (p_pin_filter) else $error("pin filter wrong"); // [R11]
   property p_status_full;
      @(posedge clk_i) disable iff (rst_i)
      cycle_i |=> image_status_o == {
         $past(err_code_i[31:28]), $past(link_state_i[31:28]), $past(err_code_i[27:24]), $past(link_state_i[27:24]),
         $past(err_code_i[23:20]), $past(link_state_i[23:20]), $past(err_code_i[19:16]), $past(link_state_i[19:16]),
         $past(err_code_i[15:12]), $past(link_state_i[15:12]), $past(err_code_i[11:8]), $past(link_state_i[11:8]),
         $past(err_code_i[7:4]), $past(link_state_i[7:4]), $past(err_code_i[3:0]), $past(link_state_i[3:0])};
   endproperty
   a_status_full: assert property (p_status_full) else $error("status bytes out of order"); // [R14]

   // ------------------------------------------------------------
   // register bus and interrupt assertions
   // ------------------------------------------------------------
   sequence s_request;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   property p_ack_follows;
      @(posedge clk_i) disable iff (rst_i)
      s_request |=> wb_ack_o;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_dat_idle;
      @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   sequence s_irq_clear_write;
      wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `ADDR_IRQ_CLR && wb_sel_i[0];
   endsequence
   property p_irq_clear;
      @(posedge clk_i) disable iff (rst_i)
      s_irq_clear_write |=> (q.irq_stat & $past(wb_dat_i[`IRQ_W-1:0]) & ~$past(ev)) == 3'h0;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt clear not taken");
   property p_irq_cycle_set;
      @(posedge clk_i) disable iff (rst_i)
      cycle_i |=> q.irq_stat[`IRQ_CYCLE_BIT];
   endproperty
   a_irq_cycle_set: assert property (p_irq_cycle_set) else $error("cycle event not latched");
   property p_irq_newmsg_set;
      @(posedge clk_i) disable iff (rst_i)
      (new_flag && !q.new_prev) |=> q.irq_stat[`IRQ_NEWMSG_BIT];
   endproperty
   a_irq_newmsg_set: assert property (p_irq_newmsg_set) else $error("new message event not latched"); // [R3]
endmodule // process_image

// ==== verification/fieldbus_reader.sv ====
// ----------------------------------------
// far-side reader of the cyclic image
// ----------------------------------------
module fieldbus_reader (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [15:0] inputs_i,
   input wire logic new_msg_i,
   input wire logic [63:0] status_i,
   input wire logic [31:0] time_i,
   output logic cycle_o,
   output logic done_o,
   output logic [112:0] snap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pend_q;
   assign cycle_o = req_i;
   // the whole image is taken at one edge, so all bytes come from one capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         done_o <= 1'b0;
         snap_o <= 113'h0;
      end else begin
         pend_q <= cycle_o;
         done_o <= pend_q;
         if (pend_q) begin
            snap_o <= {inputs_i, new_msg_i, status_i, time_i};
         end
      end
   end
endmodule // fieldbus_reader

// ==== verification/testbench.sv ====
`include "pimg_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] pin4 = 8'h00, pin2 = 8'h00;
   logic [31:0] link = 32'h0, err = 32'h0, wdat = 32'h0, rd, ts1, t1, wb_dat_o, img_ts;
   logic [31:0] cyc_n = 32'h0, t_cap = 32'h0, t_req = 32'h0, e_n = 32'h0, l_n = 32'h0;
   logic unread = 1'b0, ackp = 1'b0, req = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'h0;
   logic cycle_i, img_new, img_valid, ref_clk, wb_ack_o, irq_o, done;
   logic [15:0] img_in, exp16;
   logic [63:0] img_stat, exp64;
   logic [112:0] snap;
   int n_mismatch = 0, comparisons = 0;
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) cyc_n <= cyc_n + 32'h1;
   always @(posedge clk_i) if (cycle_i) t_cap <= cyc_n;
   always @(posedge clk_i) if (cyc && stb && !wb_ack_o) t_req <= cyc_n;
   process_image DUT (.clk_i(clk_i), .rst_i(rst_i), .pin4_i(pin4), .pin2_i(pin2), .link_state_i(link),
      .err_code_i(err), .newest_unread_i(unread), .ack_pending_i(ackp), .cycle_i(cycle_i),
      .image_inputs_o(img_in), .image_new_msg_o(img_new), .image_status_o(img_stat), .image_time_o(img_ts),
      .image_valid_o(img_valid), .ref_clock_o(ref_clk), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
   fieldbus_reader u_reader (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .inputs_i(img_in), .new_msg_i(img_new),
      .status_i(img_stat), .time_i(img_ts), .cycle_o(cycle_i), .done_o(done), .snap_o(snap));
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task conclude;
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wb(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      rd = wb_dat_o;
      if (i == 20) begin
         n_mismatch++;
         conclude;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task cap;
      int i;
      @(posedge clk_i);
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(posedge clk_i);
         if (done === 1'b1) break;
      end
      if (i == 8) begin
         n_mismatch++;
         conclude;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      int p, k;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({img_valid, ref_clk, irq_o, img_in}, 64'h0);
      wb(1'b0, `ADDR_CTRL, 32'h0, 4'hF);
      chk(rd, 32'h0);
      pin4 <= 8'hA5;
      pin2 <= 8'h3C;
      repeat (8) @(posedge clk_i);
      cap;
      for (p = 0; p < 8; p++) begin
         exp16[2*p] = pin4[p];
         exp16[2*p+1] = pin2[p];
      end
      chk(snap[112:97], exp16);
      chk(img_valid, 1'b1);
      wb(1'b1, `ADDR_CTRL, 32'h1, 4'h1);
      cap;
      chk(snap[112:97], {8'h3C, 8'hA5});
      wb(1'b0, `ADDR_CYCLE, 32'h0, 4'hF);
      chk(rd[15:0], 16'h3CA5);
      wb(1'b0, `ADDR_PINS, 32'h0, 4'hF);
      chk(rd, 32'h00003CA5);
      for (k = 0; k < 12; k++) begin
         for (p = 0; p < 8; p++) begin
            e_n[4*p+:4] = 4'((k + p) % 12);
            l_n[4*p+:4] = 4'((k + p) % 5);
            exp64[8*p+:8] = {e_n[4*p+:4], l_n[4*p+:4]};
         end
         err <= e_n;
         link <= l_n;
         cap;
         for (p = 0; p < 8; p++) chk(snap[32+8*p+:8], {4'((k + p) % 12), 4'((k + p) % 5)});
      end
      wb(1'b0, `ADDR_STAT_LO, 32'h0, 4'hF);
      chk(rd, exp64[31:0]);
      wb(1'b0, `ADDR_STAT_HI, 32'h0, 4'hF);
      chk(rd, exp64[63:32]);
      unread <= 1'b1;
      cap;
      chk(snap[96], 1'b1);
      unread <= 1'b0;
      ackp <= 1'b1;
      cap;
      chk(snap[96], 1'b0);
      wb(1'b1, `ADDR_CTRL, 32'h11, 4'h1);
      cap;
      chk(snap[96], 1'b1);
      unread <= 1'b1;
      ackp <= 1'b0;
      cap;
      chk(snap[96], 1'b0);
      wb(1'b1, `ADDR_CTRL, 32'h111, 4'h3);
      chk(ref_clk, 1'b1);
      wb(1'b0, `ADDR_CTRL, 32'h0, 4'hF);
      chk(rd, 32'h111);
      cap;
      t1 = t_cap;
      ts1 = snap[31:0];
      repeat (5) @(posedge clk_i);
      cap;
      chk(32'(snap[31:0] - ts1), 32'(t_cap - t1));
      wb(1'b0, `ADDR_TIME, 32'h0, 4'hF);
      chk(32'(rd - ts1), 32'(t_req - t1));
      chk(irq_o, 1'b0);
      wb(1'b0, `ADDR_IRQ_STAT, 32'h0, 4'hF);
      chk(rd[0], 1'b1);
      chk(rd[1], 1'b1);
      wb(1'b1, `ADDR_IRQ_EN, 32'h1, 4'h1);
      chk(irq_o, 1'b1);
      wb(1'b1, `ADDR_IRQ_CLR, 32'h7, 4'h1);
      chk(irq_o, 1'b0);
      wb(1'b0, `ADDR_IRQ_STAT, 32'h0, 4'hF);
      chk(rd[2:0], 3'h0);
      wb(1'b0, 6'h3C, 32'h0, 4'hF);
      chk(rd, 32'h0);
      cap;
      chk(irq_o, 1'b1);
      conclude;
   end
endmodule // testbench
